/* File: bench/arc_top_asserts.sv */
// Purpose: Port checks for the converter control block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Trigger select is shadowed from bus writes.
`timescale 1ns/1ps
module arc_top_asserts
    import arc_pkg::*;
#(
    parameter int CONV_CYCLES = ARC_CONV_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Bus and converter inputs.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_hardware_trigger_input,
    input wire logic [11:0] i_sample,
    // Outputs under check.
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [4:0] o_channel_select_field,
    input wire logic o_conversion_active_flag,
    input wire logic o_conversion_complete_flag
);
    logic acc, wr_one, rd_low, act, cpl, trig_sh;
    logic [4:0] wr_chan;
    logic [15:0] act_cnt;
    assign acc = i_psel && i_penable;
    assign wr_one = acc && i_pwrite && i_paddr == ARC_OFS_CTRL_ONE;
    assign rd_low = acc && !i_pwrite && i_paddr == ARC_OFS_RES_LOW;
    assign wr_chan = i_pwdata[4:0];
    assign act = o_conversion_active_flag;
    assign cpl = o_conversion_complete_flag;
    ////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            trig_sh <= 1'b0;
        else if (acc && i_pwrite && i_paddr == ARC_OFS_CTRL_TWO)
            trig_sh <= i_pwdata[ARC_BIT_TRIG_SEL];
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            act_cnt <= 16'h0;
        else if (wr_one || !act)
            act_cnt <= 16'h0;
        else
            act_cnt <= act_cnt + 16'h1;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////
    a_soft_start: assert property (wr_one && wr_chan != 5'h1f && !trig_sh |=> act)
        else $error("no start after control write");
    a_write_abort: assert property (wr_one && (trig_sh || wr_chan == 5'h1f) |=> !act)
        else $error("conversion not aborted");
    a_conv_length: assert property ($fell(act) && !$past(wr_one) |-> act_cnt == CONV_CYCLES)
        else $error("wrong conversion length");
    a_hw_start: assert property ($rose(i_hardware_trigger_input) && trig_sh
        && o_channel_select_field != 5'h1f |-> ##[1:4] act)
        else $error("no start after trigger");
    a_done_flag: assert property ($rose(cpl) |-> $past(act, 2) && !$past(act))
        else $error("complete flag without completion");
    a_flag_clear: assert property (wr_one || rd_low
        |=> !cpl || ($past(act, 2) && !$past(act)))
        else $error("complete flag not cleared");
    a_chan_field: assert property (wr_one |=> o_channel_select_field == $past(wr_chan))
        else $error("channel field not written");
    a_unmapped_err: assert property (acc && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 8'h18))
        else $error("wrong slave error");
    a_prdata_upper: assert property (o_prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_pready_high: assert property (o_pready)
        else $error("pready low");
    c_soft: cover property (wr_one ##1 act);
    c_hw: cover property (trig_sh && $rose(act));
    c_err: cover property (acc && o_pslverr);
endmodule // arc_top_asserts

bind arc_top arc_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_hardware_trigger_input(i_hardware_trigger_input), .i_sample(i_sample),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_channel_select_field(o_channel_select_field),
    .o_conversion_active_flag(o_conversion_active_flag),
    .o_conversion_complete_flag(o_conversion_complete_flag)
);

/* File: bench/test_adc_result_compare_control.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Conversion length shortened to four cycles.
// Notes:   All bus traffic uses one APB task.
`timescale 1ns/1ps
module test_adc_result_compare_control;
    import arc_pkg::*;
    localparam int CONV = 4;
    // Rows: mode, polarity, pass, compare high, compare low, sample.
    localparam logic [31:0] TAB [8] = '{32'h508007ff, 32'h40800800, 32'h70800800,
        32'h608007ff, 32'hb0600200, 32'ha06001ff, 32'h3ff80080, 32'h2ff8007f};
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_hardware_trigger_input = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, q;
    logic [11:0] i_sample = 12'h000, prev;
    logic [4:0] o_channel_select_field;
    logic o_pready, o_pslverr, o_conversion_active_flag, o_conversion_complete_flag, qerr;
    int err_total = 0;
    int compares = 0;
    always #10 i_clk = ~i_clk;
    arc_top #(.CONV_CYCLES(CONV)) dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_hardware_trigger_input(i_hardware_trigger_input), .i_sample(i_sample),
        .o_channel_select_field(o_channel_select_field),
        .o_conversion_active_flag(o_conversion_active_flag),
        .o_conversion_complete_flag(o_conversion_complete_flag)
    );
    ////////////////////////////////////////
    task automatic summarize();
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] st();
        return {30'h0, o_conversion_active_flag, o_conversion_complete_flag};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                summarize();
            end
            @(posedge i_clk);
        end
        q = o_prdata;
        qerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wait_act(input logic v);
        int n;
        n = 0;
        while (o_conversion_active_flag !== v) begin
            n++;
            if (n > 40) begin
                err_total++;
                summarize();
            end
            @(posedge i_clk);
        end
    endtask
    task automatic conv(input logic [11:0] s);
        i_sample <= s;
        bus(1'b1, ARC_OFS_CTRL_ONE, 32'h03);
        wait_act(1'b1);
        wait_act(1'b0);
        @(posedge i_clk);
    endtask
    task automatic rd_res(input logic [11:0] r);
        bus(1'b0, ARC_OFS_RES_HIGH, 32'h0);
        check("res_high", q, {28'h0, r[11:8]});
        bus(1'b0, ARC_OFS_RES_LOW, 32'h0);
        check("res_low", q, {24'h0, r[7:0]});
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            check("rst", q, (i == 0) ? 32'h1f : 32'h0);
            check("err", {31'h0, qerr}, {31'h0, i == 7});
        end
        bus(1'b1, 8'h1c, 32'hff);
        check("err", {31'h0, qerr}, 32'h1);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ARC_OFS_CONFIG, 32'(m * 4));
            i_sample <= 12'habc;
            bus(1'b1, ARC_OFS_CTRL_ONE, 32'h05);
            wait_act(1'b1);
            bus(1'b0, ARC_OFS_CTRL_TWO, 32'h0);
            check("active", q, 32'h80);
            wait_act(1'b0);
            @(posedge i_clk);
            check("st", st(), 32'h1);
            rd_res((m == 1) ? 12'habc : (m == 2) ? 12'h2bc : 12'h0bc);
            @(posedge i_clk);
            check("st", st(), 32'h0);
        end
    endtask
    task automatic t_cmp();
        logic [31:0] t;
        for (int i = 0; i < 8; i++) begin
            t = TAB[i];
            bus(1'b1, ARC_OFS_CONFIG, {28'h0, t[31:30], 2'h0});
            bus(1'b1, ARC_OFS_CMP_HIGH, {24'h0, t[27:20]});
            bus(1'b1, ARC_OFS_CMP_LOW, {24'h0, t[19:12]});
            bus(1'b0, ARC_OFS_CMP_LOW, 32'h0);
            check("cmp_low", q, {24'h0, t[19:12]});
            bus(1'b0, ARC_OFS_CMP_HIGH, 32'h0);
            check("cmp_high", q, {24'h0, t[27:20]});
            bus(1'b1, ARC_OFS_CTRL_TWO, {26'h0, 1'b1, t[29], 4'h0});
            conv(t[11:0]);
            check("st", st(), {31'h0, t[28]});
            if (t[28])
                prev = t[11:0];
            rd_res(prev);
        end
        bus(1'b1, ARC_OFS_CTRL_TWO, 32'h0);
    endtask
    task automatic t_lock();
        bus(1'b1, ARC_OFS_CONFIG, 32'h04);
        conv(12'h123);
        bus(1'b0, ARC_OFS_RES_HIGH, 32'h0);
        conv(12'h456);
        bus(1'b0, ARC_OFS_RES_LOW, 32'h0);
        check("locked", q, 32'h23);
        conv(12'h789);
        rd_res(12'h789);
        bus(1'b1, ARC_OFS_CONFIG, 32'h0);
        conv(12'h0aa);
        bus(1'b0, ARC_OFS_RES_HIGH, 32'h0);
        conv(12'h055);
        bus(1'b0, ARC_OFS_RES_LOW, 32'h0);
        check("unlocked", q, 32'h55);
    endtask
    task automatic t_abort();
        i_sample <= 12'h0ff;
        bus(1'b1, ARC_OFS_CTRL_ONE, 32'h01);
        wait_act(1'b1);
        bus(1'b1, ARC_OFS_CTRL_ONE, 32'h1f);
        repeat (CONV + 2) @(posedge i_clk);
        check("st", st(), 32'h0);
        rd_res(12'h055);
    endtask
    task automatic t_hw();
        bus(1'b1, ARC_OFS_CTRL_TWO, 32'h40);
        bus(1'b1, ARC_OFS_CTRL_ONE, 32'h02);
        repeat (3) begin
            @(posedge i_clk);
            check("st", st(), 32'h0);
            check("chan", {27'h0, o_channel_select_field}, 32'h2);
        end
        i_sample <= 12'h0c3;
        i_hardware_trigger_input <= 1'b1;
        wait_act(1'b1);
        wait_act(1'b0);
        repeat (CONV + 4) begin
            @(posedge i_clk);
            check("once", {31'h0, o_conversion_active_flag}, 32'h0);
        end
        i_hardware_trigger_input <= 1'b0;
        rd_res(12'h0c3);
        bus(1'b1, ARC_OFS_CTRL_TWO, 32'h0);
        i_hardware_trigger_input <= 1'b1;
        repeat (6) begin
            @(posedge i_clk);
            check("soft", {31'h0, o_conversion_active_flag}, 32'h0);
        end
        i_hardware_trigger_input <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_reset();
        t_modes();
        t_cmp();
        t_lock();
        t_abort();
        t_hw();
        summarize();
    end
endmodule // test_adc_result_compare_control

/* File: core/arc_conv.sv */
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Conversion sequencer that times one conversion and captures the raw sample.
// Assumes: The analog front end holds a settled 12-bit code on i_sample at the end.
// Notes:   An abort returns to idle at once unless a start comes in the same cycle; a start, even while busy, restarts the timer.
//////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module arc_conv
    import arc_pkg::*;
#(
    parameter int CONV_CYCLES = ARC_CONV_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control.
    input wire logic i_start,
    input wire logic i_abort,
    // Analog front end.
    input wire logic [11:0] i_sample,
    // Status and data.
    output logic o_busy,
    output logic o_done,
    output logic [11:0] o_data
);

    arc_state_e state;
    logic [15:0] count;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ARC_ST_IDLE;
            count <= 16'h0000;
        end else if (i_start) begin
            state <= ARC_ST_CONV;
            count <= 16'(CONV_CYCLES - 1);
        end else if (i_abort) begin
            state <= ARC_ST_IDLE;
        end else begin
            unique case (state)
                ARC_ST_IDLE: begin
                    count <= 16'h0000;
                end
                ARC_ST_CONV: begin
                    if (count == 16'h0000) begin
                        state <= ARC_ST_IDLE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                default: begin
                    state <= ARC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_done <= 1'b0;
            o_data <= 12'h000;
        end else begin
            o_done <= !i_start && !i_abort && state == ARC_ST_CONV && count == 16'h0000;
            if (!i_start && !i_abort && state == ARC_ST_CONV && count == 16'h0000) begin
                o_data <= i_sample;
            end
        end
    end

    assign o_busy = (state == ARC_ST_CONV);

endmodule // arc_conv

/* File: core/arc_top.sv */
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Trigger, active flag, automatic compare and result storage of a converter.
// Assumes: APB slave with no wait states; hardware trigger may be asynchronous to i_clk.
// Notes:   Result registers are read through APB; reads have side effects.
//////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module arc_top
    import arc_pkg::*;
#(
    parameter int CONV_CYCLES = ARC_CONV_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Hardware trigger and analog front end.
    input wire logic i_hardware_trigger_input,
    input wire logic [11:0] i_sample,
    // Converter status towards the rest of the chip.
    output logic [4:0] o_channel_select_field,
    output logic o_conversion_active_flag,
    output logic o_conversion_complete_flag
);

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic wr_cmp_high;
    logic wr_cmp_low;
    logic wr_config;
    logic rd_res_high;
    logic rd_res_low;

    // Side effects happen only in the access phase; setup only loads read data.
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    assign rd = access && !i_pwrite;

    always_comb begin
        unique case (i_paddr)
            ARC_OFS_CTRL_ONE, ARC_OFS_CTRL_TWO, ARC_OFS_RES_HIGH, ARC_OFS_RES_LOW,
            ARC_OFS_CMP_HIGH, ARC_OFS_CMP_LOW, ARC_OFS_CONFIG: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign wr_ctrl_one = wr && i_paddr == ARC_OFS_CTRL_ONE;
    assign wr_ctrl_two = wr && i_paddr == ARC_OFS_CTRL_TWO;
    assign wr_cmp_high = wr && i_paddr == ARC_OFS_CMP_HIGH;
    assign wr_cmp_low = wr && i_paddr == ARC_OFS_CMP_LOW;
    assign wr_config = wr && i_paddr == ARC_OFS_CONFIG;
    assign rd_res_high = rd && i_paddr == ARC_OFS_RES_HIGH;
    assign rd_res_low = rd && i_paddr == ARC_OFS_RES_LOW;

    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Software-written control fields.

    logic [4:0] channel;
    logic trig_sel;
    logic cmp_en;
    logic cmp_ge;
    logic [1:0] mode;
    logic [7:0] cmp_high;
    logic [7:0] cmp_low;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            channel <= ARC_RST_CHAN;
        end else if (wr_ctrl_one) begin
            channel <= i_pwdata[ARC_CHAN_MSB:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trig_sel <= 1'b0;
            cmp_en <= 1'b0;
            cmp_ge <= 1'b0;
        end else if (wr_ctrl_two) begin
            trig_sel <= i_pwdata[ARC_BIT_TRIG_SEL];
            cmp_en <= i_pwdata[ARC_BIT_CMP_EN];
            cmp_ge <= i_pwdata[ARC_BIT_CMP_GE];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode <= ARC_MODE_8;
        end else if (wr_config) begin
            mode <= i_pwdata[ARC_MODE_MSB:ARC_MODE_LSB];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_high <= ARC_RST_BYTE;
            cmp_low <= ARC_RST_BYTE;
        end else begin
            if (wr_cmp_high) begin
                cmp_high <= i_pwdata[7:0];
            end
            if (wr_cmp_low) begin
                cmp_low <= i_pwdata[7:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Hardware trigger synchroniser and edge detector.

    logic trig_meta;
    logic trig_sync;
    logic trig_last;
    logic trig_event;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_last <= 1'b0;
        end else begin
            trig_meta <= i_hardware_trigger_input;
            trig_sync <= trig_meta;
            trig_last <= trig_sync;
        end
    end

    assign trig_event = trig_sync && !trig_last;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Start and abort.

    logic chan_on;
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic [11:0] raw;
    logic soft_start;
    logic hard_start;

    assign chan_on = (channel != ARC_CHAN_OFF);
    // A control write stops a running conversion; with the software trigger and a channel other than ARC_CHAN_OFF it restarts it.
    assign abort = wr_ctrl_one;
    // A trigger edge that meets a control write is dropped; the write decides.
    assign hard_start = trig_event && chan_on && !wr_ctrl_one;
    assign soft_start = wr_ctrl_one && i_pwdata[ARC_CHAN_MSB:0] != ARC_CHAN_OFF;
    always_comb begin
        if (trig_sel) begin
            start = hard_start;
        end else begin
            start = soft_start;
        end
    end

    arc_conv #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_start(start),
        .i_abort(abort),
        .i_sample(i_sample),
        .o_busy(busy),
        .o_done(done),
        .o_data(raw)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Resolution masking and automatic compare.

    logic [11:0] result;
    logic [11:0] cmp_value;
    logic cmp_below;
    logic cmp_true;
    logic store_ok;

    always_comb begin
        unique case (mode)
            ARC_MODE_12: begin
                result = raw;
                cmp_value = {cmp_high[3:0], cmp_low};
            end
            ARC_MODE_10: begin
                result = {2'h0, raw[9:0]};
                cmp_value = {2'h0, cmp_high[1:0], cmp_low};
            end
            default: begin
                result = {4'h0, raw[7:0]};
                cmp_value = {4'h0, cmp_low};
            end
        endcase
    end

    assign cmp_below = (result < cmp_value);
    assign cmp_true = cmp_ge ? !cmp_below : cmp_below;
    assign store_ok = !cmp_en || cmp_true;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Read interlock and result registers.

    logic locked;
    logic lock_mode;
    logic take_result;
    logic [11:0] res_store;

    // Leaving the locking modes drops a pending lock, so 8-bit results land unless the compare rejects them.
    assign lock_mode = (mode == ARC_MODE_12) || (mode == ARC_MODE_10);
    assign take_result = done && store_ok && !locked;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            locked <= 1'b0;
        end else if (lock_mode) begin
            if (rd_res_low) begin
                locked <= 1'b0;
            end else if (rd_res_high) begin
                locked <= 1'b1;
            end
        end else begin
            locked <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            res_store <= 12'h000;
        end else if (take_result) begin
            res_store <= result;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Status flags.

    logic complete;
    logic set_complete;

    assign set_complete = done && store_ok;

    // An end of conversion wins over a clear that falls in the same cycle.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            complete <= 1'b0;
        end else if (set_complete) begin
            complete <= 1'b1;
        end else if (wr_ctrl_one || rd_res_low) begin
            complete <= 1'b0;
        end
    end

    assign o_conversion_active_flag = busy;
    assign o_conversion_complete_flag = complete;
    assign o_channel_select_field = channel;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup phase so it is stable through the access phase.

    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (i_paddr)
            ARC_OFS_CTRL_ONE: begin
                next_rdata = {complete, 2'h0, channel};
            end
            ARC_OFS_CTRL_TWO: begin
                // Reserved bits 3 to 0 read back as zero whatever was written.
                next_rdata = {busy, trig_sel, cmp_en, cmp_ge, 4'h0};
            end
            ARC_OFS_RES_HIGH: begin
                next_rdata = {4'h0, res_store[11:8]};
            end
            ARC_OFS_RES_LOW: begin
                next_rdata = res_store[7:0];
            end
            ARC_OFS_CMP_HIGH: begin
                next_rdata = cmp_high;
            end
            ARC_OFS_CMP_LOW: begin
                next_rdata = cmp_low;
            end
            ARC_OFS_CONFIG: begin
                next_rdata = {4'h0, mode, 2'h0};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= {24'h00_0000, next_rdata};
        end
    end

endmodule // arc_top

/* File: pkg/arc_pkg.sv */
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the converter result and compare control block.
// Assumes: 32-bit APB, one aligned word per register, 50 MHz clock.
// Notes:   Register fields are 8 bits wide and sit in the low byte of each word.
//////////////////////////////////////////////////////////////////////////////////////////////////
package arc_pkg;

    // Register byte offsets.
    localparam logic [7:0] ARC_OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] ARC_OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] ARC_OFS_RES_HIGH = 8'h08;
    localparam logic [7:0] ARC_OFS_RES_LOW = 8'h0c;
    localparam logic [7:0] ARC_OFS_CMP_HIGH = 8'h10;
    localparam logic [7:0] ARC_OFS_CMP_LOW = 8'h14;
    localparam logic [7:0] ARC_OFS_CONFIG = 8'h18;

    // Field positions in control_status_one.
    localparam int ARC_BIT_COMPLETE = 7;
    localparam int ARC_CHAN_MSB = 4;

    // Field positions in control_status_two.
    localparam int ARC_BIT_ACTIVE = 7;
    localparam int ARC_BIT_TRIG_SEL = 6;
    localparam int ARC_BIT_CMP_EN = 5;
    localparam int ARC_BIT_CMP_GE = 4;

    // Field positions in the configuration register.
    localparam int ARC_MODE_MSB = 3;
    localparam int ARC_MODE_LSB = 2;

    // Resolution codes.
    localparam logic [1:0] ARC_MODE_8 = 2'h0;
    localparam logic [1:0] ARC_MODE_12 = 2'h1;
    localparam logic [1:0] ARC_MODE_10 = 2'h2;

    // Channel code that switches the converter off.
    localparam logic [4:0] ARC_CHAN_OFF = 5'h1f;

    // Reset values.
    localparam logic [7:0] ARC_RST_BYTE = 8'h00;
    localparam logic [4:0] ARC_RST_CHAN = 5'h1f;

    // Conversion timing.
    localparam int ARC_CLK_MHZ = 50;
    localparam int ARC_CONV_TIME_NS = 2000;
    localparam int ARC_CONV_CYCLES = (ARC_CONV_TIME_NS * ARC_CLK_MHZ) / 1000;

    // Converter sequencer states.
    typedef enum logic [1:0] {
        ARC_ST_IDLE = 2'b01,
        ARC_ST_CONV = 2'b10
    } arc_state_e;

endpackage
